// [sdcbc_bank_track.sv]
// per-bank open flag and open row memory
`timescale 1ns/1ps
module sdcbc_bank_track
	import sdcbc_pkg::*;
#(
	parameter int NBANK = BANKS,
	parameter int ROW_W = ADDR_W
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic act_en,
	input wire logic pre_en,
	input wire logic pre_all,
	input wire logic [BANK_W-1:0] bank,
	input wire logic [ROW_W-1:0] row,
	output logic [NBANK-1:0] bank_open,
	output logic [ROW_W-1:0] sel_row
);
	// row held by each bank while open
	logic [ROW_W-1:0] row_mem [NBANK];

	// row of the addressed bank, for column accesses
	assign sel_row = row_mem[bank];

	// open on activate, close on precharge of this bank or all
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bank_open <= '0;
		end else begin
			for (int i = 0; i < NBANK; i++) begin
				if (act_en && bank == BANK_W'(i)) begin
					bank_open[i] <= 1'b1;
				end else if (pre_en && (pre_all || bank == BANK_W'(i))) begin
					bank_open[i] <= 1'b0;
				end
			end
		end
	end

	// row store needs no reset; column accesses read it only while the bank is open, a precharge reads it even when closed
	always_ff @(posedge core_clk) begin
		if (act_en) begin
			row_mem[bank] <= row;
		end
	end
endmodule : sdcbc_bank_track

// [sdcbc_dq_lane.sv]
// read data timing and per-byte output float on the data pins
`timescale 1ns/1ps
module sdcbc_dq_lane
	import sdcbc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic slot,
	input wire logic cl3,
	input wire logic [1:0] mask,
	input wire logic [DATA_W-1:0] rdata,
	output logic [DATA_W-1:0] dout,
	output logic [1:0] oe
);
	logic [1:0] mask_d1_q; // mask one edge old
	logic [DATA_W-1:0] rdata_d1_q; // array word one edge old, for latency three

	// mask float lands two edges after sampling, data at the latency slot
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_d1_q <= 2'h0;
			rdata_d1_q <= '0;
			dout <= '0;
			oe <= 2'h0;
		end else begin
			mask_d1_q <= mask;
			rdata_d1_q <= rdata;
			dout <= cl3 ? rdata_d1_q : rdata;
			oe <= {slot & ~mask_d1_q[1], slot & ~mask_d1_q[0]};
		end
	end
endmodule : sdcbc_dq_lane

// [sdcbc_host_model.sv]
// host controller model that drives the sdram pins from the far side
`timescale 1ns/1ps
module sdcbc_host_model
	import sdcbc_pkg::*;
#(
	parameter int PAUSE_CYC = 8000,
	parameter int GAP_CYC = 2
) (
	input wire logic core_clk,
	output logic [3:0] cmd_n,
	output logic clock_gate,
	output logic [BANK_W-1:0] bank,
	output logic [ADDR_W-1:0] addr,
	output logic [1:0] mask,
	output logic [DATA_W-1:0] hdat,
	output logic hdat_en
);
	initial begin
		cmd_n = 4'h7;
		clock_gate = 1'b1;
		bank = 2'h0;
		addr = 13'h0000;
		mask = 2'h3;
		hdat = 16'h0000;
		hdat_en = 1'b0;
	end

	// one command per call; data is only driven with a write
	task automatic put(input logic [3:0] c, input logic [BANK_W-1:0] b,
		input logic [ADDR_W-1:0] a, input logic [1:0] m, input logic [DATA_W-1:0] d);
		@(negedge core_clk);
		cmd_n = c;
		bank = b;
		addr = a;
		mask = m;
		hdat_en = (c == 4'h4);
		hdat = hdat_en ? d : ~hdat;
	endtask : put

	// quiet cycles; released data toggles so no stale value is seen
	task automatic idle(input int n);
		repeat (n) begin
			@(negedge core_clk);
			cmd_n = 4'h7;
			hdat_en = 1'b0;
			hdat = ~hdat;
		end
	endtask : idle

	// start-up sequence; mode is unknown until it is programmed
	task automatic init(input logic [ADDR_W-1:0] mode);
		int i;
		put(4'h7, 2'h0, 13'h0000, 2'h3, 16'h0000);
		idle(PAUSE_CYC);
		put(4'h2, 2'h0, 13'h0400, 2'h0, 16'h0000);
		idle(GAP_CYC);
		for (i = 0; i < 8; i++) begin
			put(4'h1, 2'h0, 13'h0000, 2'h0, 16'h0000);
			idle(GAP_CYC);
		end
		put(4'h0, 2'h0, mode, 2'h0, 16'h0000);
		idle(GAP_CYC);
	endtask : init
endmodule : sdcbc_host_model

// [sdcbc_pkg.sv]
// constants, command and power-state types shared by the sdram front end
package sdcbc_pkg;
	// array geometry
	localparam int ADDR_W = 13;
	localparam int COL_W = 9;
	localparam int BANKS = 4;
	localparam int BANK_W = 2;
	localparam int DATA_W = 16;
	// address bit that widens a precharge to every bank
	localparam int PRE_ALL_BIT = 10;
	// mode word fields
	localparam int MODE_BL_LSB = 0;
	localparam int MODE_BT_BIT = 3;
	localparam int MODE_CL_LSB = 4;
	localparam logic [2:0] CL_THREE = 3'h3;
	localparam logic [ADDR_W-1:0] MODE_RST = 13'h0000;
	// pin bundle width and reset: strobes and clock gate idle high, everything else low;
	// a low gate here would fake a power-down entry on the first edge after reset
	localparam int PIN_W = 38;
	localparam logic [PIN_W-1:0] PIN_RST = 38'h3e_0000_0000;

	// decoded command at a sampled edge
	typedef enum logic [3:0] {
		CMD_DESELECT = 4'h0,
		CMD_NO_OPERATION = 4'h1,
		CMD_ACTIVATE = 4'h2,
		CMD_READ = 4'h3,
		CMD_WRITE = 4'h4,
		CMD_PRECHARGE = 4'h5,
		CMD_AUTO_REFRESH = 4'h6,
		CMD_MODE_SET = 4'h7,
		CMD_BURST_STOP = 4'h8
	} sdcbc_cmd_e;

	// clock-gate driven power states, one-hot
	typedef enum logic [3:0] {
		PS_RUN = 4'h1,
		PS_POWER_DOWN = 4'h2,
		PS_SUSPEND = 4'h4,
		PS_SELF_REFRESH = 4'h8
	} sdcbc_power_e;

	// strobe levels to command; chip select high means deselect
	function automatic sdcbc_cmd_e sdcbc_decode(input logic cs_n, input logic ras_n,
		input logic cas_n, input logic we_n);
		sdcbc_cmd_e c;
		c = CMD_DESELECT;
		if (!cs_n) begin
			case ({ras_n, cas_n, we_n})
				3'h7: c = CMD_NO_OPERATION;
				3'h3: c = CMD_ACTIVATE;
				3'h5: c = CMD_READ;
				3'h4: c = CMD_WRITE;
				3'h2: c = CMD_PRECHARGE;
				3'h1: c = CMD_AUTO_REFRESH;
				3'h0: c = CMD_MODE_SET;
				default: c = CMD_BURST_STOP;
			endcase
		end
		return c;
	endfunction : sdcbc_decode
endpackage : sdcbc_pkg

// [sdcbc_top.sv]
// command decoder, bank control, byte masking and power states of the sdram
// Overview of operation
// - row uses all address bits, column low nine
// - bank select picks activated or accessed bank
// - deselect ignores commands, work in flight continues
// - strobes decoded at each sampled rising edge
// - read mask high floats byte two cycles later
// - write mask high blocks that byte immediately
// - clock gate low enters low-power state
// - all strobes low loads mode from address
// - column access: read or write by write strobe
// - column commands accepted on every cycle
// - four banks of sixteen-bit words, own state
// - mode holds burst length, order, read latency
// - precharge one bank or all via bit ten
`timescale 1ns/1ps
module sdcbc_top
	import sdcbc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic chip_select_n,
	input wire logic row_strobe_n,
	input wire logic col_strobe_n,
	input wire logic write_strobe_n,
	input wire logic clock_gate,
	input wire logic bank_select_lo,
	input wire logic bank_select_hi,
	input wire logic [ADDR_W-1:0] address_bus,
	input wire logic lower_byte_mask,
	input wire logic upper_byte_mask,
	input wire logic [DATA_W-1:0] data_bus_in,
	output logic [DATA_W-1:0] data_bus_out,
	output logic [1:0] data_bus_oe,
	input wire logic [DATA_W-1:0] array_rdata,
	output logic array_act_q,
	output logic array_rd_q,
	output logic array_wr_q,
	output logic array_pre_q,
	output logic array_ref_q,
	output logic [BANK_W-1:0] array_bank_q,
	output logic [ADDR_W-1:0] array_row_q,
	output logic [COL_W-1:0] array_col_q,
	output logic [DATA_W-1:0] array_wdata_q,
	output logic [1:0] array_wbe_q,
	output logic [ADDR_W-1:0] mode_q,
	output logic mode_valid_q,
	output logic cmd_error_q,
	output logic [BANKS-1:0] bank_open,
	output logic [3:0] power_q
);
	// two-flop pin synchroniser; only stage two is read
	logic [PIN_W-1:0] pin_s1_q;
	logic [PIN_W-1:0] pin_s2_q;
	logic [PIN_W-1:0] pin_raw;

	assign pin_raw = {chip_select_n, row_strobe_n, col_strobe_n, write_strobe_n, clock_gate,
		bank_select_hi, bank_select_lo, address_bus, upper_byte_mask, lower_byte_mask,
		data_bus_in};

	// resets to deselect so nothing decodes before the pins settle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_q <= PIN_RST;
			pin_s2_q <= PIN_RST;
		end else begin
			pin_s1_q <= pin_raw;
			pin_s2_q <= pin_s1_q;
		end
	end

	// sampled pin fields
	logic cs_s;
	logic ras_s;
	logic cas_s;
	logic we_s;
	logic cke_s;
	logic [BANK_W-1:0] bank_s;
	logic [ADDR_W-1:0] addr_s;
	logic [1:0] mask_s;
	logic [DATA_W-1:0] din_s;

	assign {cs_s, ras_s, cas_s, we_s, cke_s} = pin_s2_q[PIN_W-1 -: 5];
	assign bank_s = pin_s2_q[PIN_W-6 -: BANK_W];
	assign addr_s = pin_s2_q[PIN_W-8 -: ADDR_W];
	assign mask_s = pin_s2_q[DATA_W+1 -: 2];
	assign din_s = pin_s2_q[DATA_W-1:0];

	sdcbc_cmd_e cmd_w;
	assign cmd_w = sdcbc_decode(cs_s, ras_s, cas_s, we_s);

	// commands count only in run state with the gate still high
	logic cmd_live;
	assign cmd_live = (power_q == PS_RUN) && cke_s;

	// bank state of the addressed bank
	logic sel_open;
	logic any_open;
	logic [ADDR_W-1:0] sel_row;
	assign sel_open = bank_open[bank_s];
	assign any_open = |bank_open;

	logic act_ok;
	logic rd_ok;
	logic wr_ok;
	logic pre_ok;
	logic ref_ok;
	logic mrs_ok;
	logic bad_cmd;
	assign act_ok = cmd_live && cmd_w == CMD_ACTIVATE && !sel_open;
	assign rd_ok = cmd_live && cmd_w == CMD_READ && sel_open;
	assign wr_ok = cmd_live && cmd_w == CMD_WRITE && sel_open;
	assign pre_ok = cmd_live && cmd_w == CMD_PRECHARGE;
	assign ref_ok = cmd_live && cmd_w == CMD_AUTO_REFRESH && !any_open;
	assign mrs_ok = cmd_live && cmd_w == CMD_MODE_SET && !any_open;
	assign bad_cmd = cmd_live && ((cmd_w == CMD_ACTIVATE && sel_open)
		|| ((cmd_w == CMD_READ || cmd_w == CMD_WRITE) && !sel_open)
		|| ((cmd_w == CMD_AUTO_REFRESH || cmd_w == CMD_MODE_SET) && any_open));

	sdcbc_bank_track #(
		.NBANK(BANKS),
		.ROW_W(ADDR_W)
	) u_banks (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.act_en(act_ok),
		.pre_en(pre_ok),
		.pre_all(addr_s[PRE_ALL_BIT]),
		.bank(bank_s),
		.row(addr_s),
		.bank_open(bank_open),
		.sel_row(sel_row)
	);

	// new command every cycle
	// array strobes: one-cycle pulses, one edge after the sampled command
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			array_act_q <= 1'b0;
			array_rd_q <= 1'b0;
			array_wr_q <= 1'b0;
			array_pre_q <= 1'b0;
			array_ref_q <= 1'b0;
			cmd_error_q <= 1'b0;
		end else begin
			array_act_q <= act_ok;
			array_rd_q <= rd_ok;
			array_wr_q <= wr_ok;
			array_pre_q <= pre_ok;
			array_ref_q <= ref_ok;
			cmd_error_q <= bad_cmd;
		end
	end

	// row on activate, column from low nine bits
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			array_bank_q <= '0;
			array_row_q <= '0;
			array_col_q <= '0;
		end else if (act_ok || rd_ok || wr_ok || pre_ok) begin
			array_bank_q <= bank_s;
			array_row_q <= act_ok ? addr_s : sel_row;
			array_col_q <= addr_s[COL_W-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			array_wdata_q <= '0;
			array_wbe_q <= 2'h0;
		end else begin
			array_wdata_q <= din_s;
			array_wbe_q <= wr_ok ? ~mask_s : 2'h0;
		end
	end

	// burst and latency fields held here
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= MODE_RST;
			mode_valid_q <= 1'b0;
		end else if (mrs_ok) begin
			mode_q <= addr_s;
			mode_valid_q <= 1'b1;
		end
	end

	// read latency of three selected; anything else runs at two
	logic cl3;
	assign cl3 = mode_q[MODE_CL_LSB +: 3] == CL_THREE;

	// read slot pipe; keeps running across deselect so reads finish
	logic [1:0] rd_pipe_q;
	logic out_slot;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_pipe_q <= 2'h0;
		end else begin
			rd_pipe_q <= {rd_pipe_q[0], rd_ok};
		end
	end
	assign out_slot = cl3 ? rd_pipe_q[1] : rd_pipe_q[0];

	sdcbc_dq_lane u_dq (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.slot(out_slot),
		.cl3(cl3),
		.mask(mask_s),
		.rdata(array_rdata),
		.dout(data_bus_out),
		.oe(data_bus_oe)
	);

	sdcbc_power_e power_d;
	logic busy;
	assign busy = (|rd_pipe_q) || array_rd_q || array_wr_q;

	always_comb begin
		power_d = sdcbc_power_e'(power_q);
		case (power_q)
			PS_RUN: begin
				if (!cke_s) begin
					if (cmd_w == CMD_AUTO_REFRESH && !any_open) begin
						power_d = PS_SELF_REFRESH;
					end else if (busy) begin
						power_d = PS_SUSPEND;
					end else begin
						power_d = PS_POWER_DOWN;
					end
				end
			end
			PS_POWER_DOWN, PS_SUSPEND, PS_SELF_REFRESH: begin
				if (cke_s) begin
					power_d = PS_RUN;
				end
			end
			default: power_d = PS_RUN;
		endcase
	end

	// power state register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			power_q <= PS_RUN;
		end else begin
			power_q <= power_d;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_cs_deselect_quiet: assert property (cs_s |=> !(array_act_q || array_rd_q ||
		array_wr_q || array_pre_q || array_ref_q))
		else $error("deselect produced an array command");
	a_pre_decode: assert property ((cmd_live && !ras_s && cas_s && !we_s && !cs_s)
		|=> array_pre_q)
		else $error("precharge strobes not decoded");
	a_pre_all_close: assert property ((pre_ok && addr_s[PRE_ALL_BIT]) |=> bank_open == '0)
		else $error("precharge all left a bank open");
	a_act_bank_row: assert property (act_ok |=> array_act_q && array_bank_q == $past(bank_s)
		&& array_row_q == $past(addr_s) && bank_open[array_bank_q])
		else $error("activate bank or row wrong");
	a_col_low_bits: assert property ((rd_ok || wr_ok) |=>
		array_col_q == $past(addr_s[COL_W-1:0]))
		else $error("column address wrong");
	a_wr_mask_now: assert property (wr_ok |=> array_wr_q && array_wbe_q == ~$past(mask_s))
		else $error("write byte mask not applied");
	a_rd_mask_float: assert property ((rd_ok && !cl3 && mask_s[0]) |-> ##2 !data_bus_oe[0])
		else $error("masked lane driven on read");
	a_rd_lane_drive: assert property ((rd_ok && !cl3 && !mask_s[1]) |-> ##2 data_bus_oe[1])
		else $error("unmasked lane not driven");
	a_closed_bank_err: assert property ((cmd_live && cmd_w == CMD_READ && !sel_open)
		|=> cmd_error_q && !array_rd_q)
		else $error("read to closed bank not refused");
	a_b2b_reads: assert property (((rd_ok || wr_ok) ##1 (rd_ok || wr_ok)) |->
		(array_rd_q || array_wr_q) ##1 (array_rd_q || array_wr_q))
		else $error("back to back reads dropped");
	a_gate_low_exit: assert property ((power_q == PS_RUN && !cke_s) |=>
		power_q != PS_RUN ##1 ($past(cke_s) || power_q != PS_RUN))
		else $error("clock gate low kept run state");
	a_mode_load: assert property (mrs_ok |=> mode_valid_q && mode_q == $past(addr_s))
		else $error("mode word not loaded");

	c_act_then_read: cover property (act_ok ##[1:8] rd_ok);
	c_write_masked: cover property (wr_ok && mask_s != 2'h0);
	c_self_refresh: cover property (power_q == PS_SELF_REFRESH);
	c_suspend: cover property (power_q == PS_SUSPEND);
	c_mode_set: cover property (mrs_ok);
endmodule : sdcbc_top

// [testbench.sv]
// self-checking bench for the sdram command front end
`timescale 1ns/1ps
module testbench
	import sdcbc_pkg::*;
;
	// pins between host model and device
	logic core_clk;
	logic rst_n;
	logic [3:0] cmd_n;
	logic gate;
	logic [BANK_W-1:0] bank;
	logic [ADDR_W-1:0] addr;
	logic [1:0] mask;
	logic [DATA_W-1:0] hdat;
	logic hdat_en;
	logic [DATA_W-1:0] dout;
	logic [1:0] oe;
	// array side and status of the device
	logic act, rd, wr, pre, rfr, mvalid, cerr;
	logic [BANK_W-1:0] abank;
	logic [ADDR_W-1:0] arow, mode, md;
	logic [COL_W-1:0] acol;
	logic [DATA_W-1:0] awd;
	logic [1:0] awbe;
	logic [BANKS-1:0] bopen;
	logic [3:0] pwr;
	// bench state; rows remembers what each bank holds open
	int errors = 0, compares = 0, cycles = 0, nref = 0, i, cl;
	logic [31:0] seed;
	logic [ADDR_W-1:0] rows [BANKS];
	// refused or hidden commands, and which of them pulse an error
	logic [3:0] bad_cmd [5] = '{4'h3, 4'hb, 4'h0, 4'h1, 4'h6};
	logic [4:0] bad_err = 5'h0d;

	// xorshift step for repeatable stimulus
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	// array word built from its place, so a wrong row or bank shows
	function automatic logic [DATA_W-1:0] word(input logic [BANK_W-1:0] b,
		input logic [ADDR_W-1:0] r, input logic [COL_W-1:0] c);
		return {b, c, r[4:0] ^ r[12:8]};
	endfunction : word

	// device lane drives when enabled, else the host pattern
	logic [DATA_W-1:0] dat_wire;
	assign dat_wire = {oe[1] ? dout[15:8] : hdat[15:8], oe[0] ? dout[7:0] : hdat[7:0]};
	// array answers in the read cycle only, a flipped word otherwise
	logic [DATA_W-1:0] ardat;
	assign ardat = rd ? word(abank, arow, acol) : ~word(abank, arow, acol);

	// start-up pause shortened from 8000 cycles to keep the run short
	sdcbc_host_model #(.PAUSE_CYC(40), .GAP_CYC(2)) sdcbc_host_model_inst (
		.core_clk(core_clk),
		.cmd_n(cmd_n),
		.clock_gate(gate),
		.bank(bank),
		.addr(addr),
		.mask(mask),
		.hdat(hdat),
		.hdat_en(hdat_en)
	);

	sdcbc_top sdcbc_top_inst (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.chip_select_n(cmd_n[3]),
		.row_strobe_n(cmd_n[2]),
		.col_strobe_n(cmd_n[1]),
		.write_strobe_n(cmd_n[0]),
		.clock_gate(gate),
		.bank_select_lo(bank[0]),
		.bank_select_hi(bank[1]),
		.address_bus(addr),
		.lower_byte_mask(mask[0]),
		.upper_byte_mask(mask[1]),
		.data_bus_in(dat_wire),
		.data_bus_out(dout),
		.data_bus_oe(oe),
		.array_rdata(ardat),
		.array_act_q(act),
		.array_rd_q(rd),
		.array_wr_q(wr),
		.array_pre_q(pre),
		.array_ref_q(rfr),
		.array_bank_q(abank),
		.array_row_q(arow),
		.array_col_q(acol),
		.array_wdata_q(awd),
		.array_wbe_q(awbe),
		.mode_q(mode),
		.mode_valid_q(mvalid),
		.cmd_error_q(cerr),
		.bank_open(bopen),
		.power_q(pwr)
	);

	// 40 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// cycle ceiling far above the expected run; counts refresh pulses
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (rfr === 1'b1) nref <= nref + 1;
		if (cycles == 20000) begin
			errors++;
			summarize();
		end
	end

	// one compare for every value, reported at once
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// verdict and end of run
	task automatic summarize;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize

	task automatic op(input logic [3:0] c, input logic [BANK_W-1:0] b,
		input logic [ADDR_W-1:0] a, input logic [1:0] m, input logic [DATA_W-1:0] d);
		sdcbc_host_model_inst.put(c, b, a, m, d);
		sdcbc_host_model_inst.idle(3);
	endtask : op

	// open a bank on a random row
	task automatic act_chk(input logic [BANK_W-1:0] b);
		seed = xs(seed);
		rows[b] = seed[ADDR_W-1:0];
		op(4'h3, b, rows[b], 2'h0, 16'h0000);
		chk({act, bopen[b], abank}, {2'h3, b});
		chk(arow, rows[b]);
	endtask : act_chk

	// one column access; read data lands a latency later
	task automatic acc(input logic w, input logic [BANK_W-1:0] b, input logic [COL_W-1:0] c,
		input logic [1:0] m, input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] lm;
		lm = {{8{~m[1]}}, {8{~m[0]}}};
		op(w ? 4'h4 : 4'h5, b, {4'h0, c}, m, d);
		chk({wr, rd, arow}, {w, ~w, rows[b]});
		chk({abank, acol}, {b, c});
		if (w) begin
			chk(awd, d);
			chk(awbe ^ m, 16'h0003);
		end else begin
			repeat (cl - 1) @(negedge core_clk);
			chk(oe ^ m, 16'h0003);
			chk(dout & lm, word(b, rows[b], c) & lm);
			@(negedge core_clk);
			chk(oe, 16'h0000);
		end
	endtask : acc

	initial begin
		cl = 2;
		md = 13'h0020;
		seed = 32'h1c8c;
		rst_n = 1'b0;
		repeat (20) @(negedge core_clk);
		rst_n = 1'b1;
		sdcbc_host_model_inst.init(md);
		sdcbc_host_model_inst.idle(1);
		chk(nref[15:0], 16'h0008);
		chk({mvalid, mode}, {1'b1, md});
		for (cl = 2; cl < 4; cl++) begin
			if (cl == 3) begin
				md = {seed[12:7], 3'h3, seed[3:0]};
				op(4'h0, 2'h0, md, 2'h0, 16'h0000);
				chk(mode, md);
			end
			for (i = 0; i < BANKS; i++) act_chk(i[1:0]);
			for (i = 0; i < 30; i++) begin
				seed = xs(seed);
				acc(seed[31], seed[1:0], seed[10:2], seed[12:11], seed[28:13]);
			end
			sdcbc_host_model_inst.put(4'h5, 2'h0, 13'h0001, 2'h0, 16'h0000);
			sdcbc_host_model_inst.put(4'h4, 2'h1, 13'h0002, 2'h0, 16'h00ff);
			sdcbc_host_model_inst.idle(2);
			chk({rd, abank, acol}, {3'h4, 9'h001});
			@(negedge core_clk);
			chk({wr, abank, acol}, {3'h5, 9'h002});
			for (i = 0; i < 5; i++) begin
				op(bad_cmd[i], 2'h2, 13'h0000, 2'h0, 16'h0000);
				chk({act, rd, wr, rfr, cerr}, {4'h0, bad_err[i]});
				chk(mode, md);
			end
			// one bank, then a read to it
			op(4'h2, 2'h3, 13'h0000, 2'h0, 16'h0000);
			chk({pre, bopen}, 5'h17);
			op(4'h5, 2'h3, 13'h0000, 2'h0, 16'h0000);
			chk({rd, cerr}, 2'h1);
			op(4'h2, 2'h0, 13'h0400, 2'h0, 16'h0000);
			chk({pre, bopen}, 5'h10);
		end
		// gate low: power down, self refresh, suspend behind a read
		for (i = 0; i < 3; i++) begin
			if (i == 2) act_chk(2'h0);
			sdcbc_host_model_inst.put(i == 2 ? 4'h5 : (i ? 4'h1 : 4'h7), 2'h0, 13'h0000, 2'h0,
				16'h0000);
			// read must be taken with the gate high, so lower it one cycle later
			if (i == 2) @(negedge core_clk);
			sdcbc_host_model_inst.clock_gate = 1'b0;
			op(4'h3, 2'h0, 13'h0000, 2'h0, 16'h0000);
			chk({act, pwr}, i == 2 ? 5'h04 : (i ? 5'h08 : 5'h02));
			sdcbc_host_model_inst.clock_gate = 1'b1;
			sdcbc_host_model_inst.idle(3);
			chk(pwr, 4'h1);
		end
		summarize();
	end
endmodule : testbench
